// ### dtf_task_file.sv
`timescale 1ns/100ps
`default_nettype none
`include "dtf_map.svh"

// Behaviour
// - Command write clears upper byte select
// - Soft reset bit holds device in reset
// - Interrupt only when enabled and selected
// - Write gate reads zero while writing
// - Head bits read back inverted
// - Device/head bit 6 picks CHS/LBA
// - LBA bits 24-27 updated at end
// - Error register valid after every command
// - Diagnostic code after reset or diagnostic
// - Error bits report CRC, data, sector, track
// - Abort bit; bits 5,3,0 zero
// - Zero count means 256 or 65536
// - Count zero on success, remainder else
// - Sector register holds address, previous byte
// - Status read acknowledges interrupt
// - Busy makes every read return status
// - Ready low after power-up, after error
// - Fault and corrected flags read zero
// - Seek flag frozen after error
// - Error flag cleared by next command
// - Reset loads default register values
// - Alternate status read leaves interrupt pending
module dtf_task_file
    import dtf_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Host task-file port
    input wire dtf_host_s hostReq,
    output logic [7:0] rdData,
    output logic intrq,
    // Drive engine state and reports
    input wire dtf_drive_s drive,
    input wire dtf_done_s done,
    // Command hand-off to the drive engine
    output logic cmdStrobe,
    output logic [7:0] cmdCode,
    output logic [7:0] featureCode,
    output logic devReset,
    output logic lbaMode,
    output logic [8:0] count28,
    output logic [16:0] count48
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------

    // Sector total with zero meaning full range
    function automatic logic [16:0] sectorTotal(input logic [15:0] raw, input logic wide);
        logic [16:0] total;
        total = {1'b0, raw};
        if (raw == 16'h0000) begin
            total = wide ? 17'h10000 : 17'h00100;
        end
        return total;
    endfunction : sectorTotal

    // Access decode for one select code
    function automatic logic hits(input dtf_host_s req, input logic [2:0] code);
        return req.sel == code;
    endfunction : hits

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic upperSel; // High-order byte select
    logic softReset; // Soft reset bit
    logic ienN; // Interrupt enable, active low sense
    logic [7:0] countCur; // Latest written count
    logic [7:0] countPrev; // Previous content of count
    logic [7:0] sectorCur; // Latest written sector
    logic [7:0] sectorPrev; // Previous content of sector
    logic [7:0] devHead; // Device/head register
    logic [7:0] errReg; // Error or diagnostic code
    logic errFlag; // Status error flag
    logic readyHold; // Ready forced low after error
    logic seekFrozen; // Seek flag frozen after error
    logic seekHeld; // Seek value while frozen
    logic pending; // Interrupt pending
    logic taskRst; // Task file held in reset
    logic devSelected; // Device/head selects this device
    logic wrAccept; // Task-file write taken
    logic statusRead; // Status read with acknowledge
    logic [7:0] statusNow; // Live status byte
    logic [7:0] drvAddr; // Drive address byte
    logic [7:0] next_rdData; // Read multiplexer
    localparam logic [7:0] DevCtlRst = `DTF_RST_DEVCTL; // Device control reset byte

    // Task file is cleared by the bus reset and by soft reset
    assign taskRst = !rst_b || softReset;
    assign devReset = softReset;
    assign devSelected = devHead[`DTF_DH_DEV] == `DTF_DEV_ID;
    assign lbaMode = devHead[`DTF_DH_LBA];
    // Writes during busy are dropped; only device control gets through
    assign wrAccept = hostReq.wr && !drive.busy && !softReset;
    assign statusRead = hostReq.rd && hits(hostReq, `DTF_SEL_STATCMD);

    // ----------------------------------------
    // Device control
    // ----------------------------------------

    // Only bits 7, 2 and 1 are kept; reads at this select return status, not this register
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            upperSel <= DevCtlRst[`DTF_DC_UPPER];
            softReset <= DevCtlRst[`DTF_DC_SOFT_RESET_BIT];
            ienN <= DevCtlRst[`DTF_DC_IEN];
        end else if (hostReq.wr && hits(hostReq, `DTF_SEL_ALT)) begin
            upperSel <= hostReq.wdata[`DTF_DC_UPPER];
            softReset <= hostReq.wdata[`DTF_DC_SOFT_RESET_BIT];
            ienN <= hostReq.wdata[`DTF_DC_IEN];
        end else if (wrAccept && hits(hostReq, `DTF_SEL_STATCMD)) begin
            upperSel <= 1'b0;
        end
    end

    // ----------------------------------------
    // Command hand-off
    // ----------------------------------------

    // Strobe and code both come from flops, one cycle after the write
    always_ff @(posedge mclk) begin
        if (taskRst) begin
            cmdStrobe <= 1'b0;
            cmdCode <= 8'h00;
        end else begin
            cmdStrobe <= wrAccept && hits(hostReq, `DTF_SEL_STATCMD);
            if (wrAccept && hits(hostReq, `DTF_SEL_STATCMD)) begin
                cmdCode <= hostReq.wdata;
            end
        end
    end

    // Feature byte for the next command
    always_ff @(posedge mclk) begin
        if (taskRst) begin
            featureCode <= 8'h00;
        end else if (wrAccept && hits(hostReq, `DTF_SEL_ERRFEAT)) begin
            featureCode <= hostReq.wdata;
        end
    end

    // Sector totals frozen at command write
    always_ff @(posedge mclk) begin
        if (taskRst) begin
            count28 <= 9'h000;
            count48 <= 17'h00000;
        end else if (wrAccept && hits(hostReq, `DTF_SEL_STATCMD)) begin
            count28 <= 9'(sectorTotal({8'h00, countCur}, 1'b0));
            count48 <= sectorTotal({countPrev, countCur}, 1'b1);
        end
    end

    // ----------------------------------------
    // Count, sector and device/head
    // ----------------------------------------

    // A write pushes the latest byte into the previous slot
    always_ff @(posedge mclk) begin
        if (taskRst) begin
            countCur <= `DTF_RST_COUNT;
            countPrev <= `DTF_RST_COUNT;
        end else if (done.valid) begin
            countCur <= done.ok ? 8'h00 : done.remain;
        end else if (wrAccept && hits(hostReq, `DTF_SEL_COUNT)) begin
            countPrev <= countCur;
            countCur <= hostReq.wdata;
        end
    end

    // Sector byte; in LBA mode it carries address bits 0-7
    always_ff @(posedge mclk) begin
        if (taskRst) begin
            sectorCur <= `DTF_RST_SECTOR;
            sectorPrev <= `DTF_RST_SECTOR;
        end else if (done.valid) begin
            sectorCur <= done.sectorNow;
        end else if (wrAccept && hits(hostReq, `DTF_SEL_SECTOR)) begin
            sectorPrev <= sectorCur;
            sectorCur <= hostReq.wdata;
        end
    end

    // Head nibble also holds LBA bits 24-27 in LBA mode
    always_ff @(posedge mclk) begin
        if (taskRst) begin
            devHead <= `DTF_RST_DEVHEAD;
        end else if (done.valid) begin
            devHead[3:0] <= done.headNow;
        end else if (wrAccept && hits(hostReq, `DTF_SEL_DEVHEAD)) begin
            devHead <= hostReq.wdata;
        end
    end

    // ----------------------------------------
    // Error register and error flag
    // ----------------------------------------

    // Diagnostic code after reset or diagnostic, masked error bits else
    always_ff @(posedge mclk) begin
        if (taskRst) begin
            errReg <= `DTF_DIAG_PASS;
        end else if (done.valid && done.isDiag) begin
            errReg <= done.errBits;
        end else if (done.valid) begin
            errReg <= done.errBits & `DTF_ERR_MASK;
        end
    end

    // Completion outranks a command write in the same cycle
    always_ff @(posedge mclk) begin
        if (taskRst) begin
            errFlag <= 1'b0;
        end else if (done.valid) begin
            errFlag <= !done.ok;
        end else if (wrAccept && hits(hostReq, `DTF_SEL_STATCMD)) begin
            errFlag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Ready and seek holds
    // ----------------------------------------

    // A failing completion wins over a status read in the same cycle
    always_ff @(posedge mclk) begin
        if (taskRst) begin
            readyHold <= 1'b0;
        end else if (done.valid && !done.ok) begin
            readyHold <= 1'b1;
        end else if (statusRead) begin
            readyHold <= 1'b0;
        end
    end

    // Seek flag snapshot taken at the error
    always_ff @(posedge mclk) begin
        if (taskRst) begin
            seekFrozen <= 1'b0;
            seekHeld <= 1'b0;
        end else if (done.valid && !done.ok) begin
            seekFrozen <= 1'b1;
            seekHeld <= seekFrozen ? seekHeld : drive.seekDone;
        end else if (statusRead) begin
            seekFrozen <= 1'b0;
        end
    end

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------

    // Set wins over the acknowledge so no completion is lost
    always_ff @(posedge mclk) begin
        if (taskRst) begin
            pending <= 1'b0;
        end else if (done.valid) begin
            pending <= 1'b1;
        end else if (statusRead) begin
            pending <= 1'b0;
        end
    end

    // Request line gated by enable and selection
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            intrq <= 1'b0;
        end else begin
            intrq <= pending && !ienN && devSelected && !softReset;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------

    // Live status byte; fault and corrected never set
    always_comb begin
        statusNow = 8'h00;
        statusNow[`DTF_ST_BUSY] = drive.busy;
        statusNow[`DTF_ST_READY] = drive.powerReady && !readyHold;
        statusNow[`DTF_ST_SEEK] = seekFrozen ? seekHeld : drive.seekDone;
        statusNow[3] = drive.data_request_flag;
        statusNow[1] = drive.index;
        statusNow[`DTF_ST_ERR] = errFlag;
    end

    // Drive address: undriven bit reads zero since pins cannot float here
    always_comb begin
        drvAddr = 8'h00;
        drvAddr[6] = !drive.writing;
        drvAddr[5:2] = ~drive.head;
        drvAddr[1] = !(devSelected && `DTF_DEV_ID == 1'b1);
        drvAddr[0] = !(devSelected && `DTF_DEV_ID == 1'b0);
    end

    // Register multiplexer; busy forces status onto every read
    always_comb begin
        next_rdData = 8'h00;
        if (drive.busy) begin
            next_rdData = statusNow;
        end else begin
            case (hostReq.sel)
                `DTF_SEL_ALT: next_rdData = statusNow;
                `DTF_SEL_ERRFEAT: next_rdData = errReg;
                `DTF_SEL_COUNT: next_rdData = upperSel ? countPrev : countCur;
                `DTF_SEL_SECTOR: next_rdData = upperSel ? sectorPrev : sectorCur;
                `DTF_SEL_DRVADDR: next_rdData = drvAddr;
                `DTF_SEL_DEVHEAD: next_rdData = devHead;
                `DTF_SEL_STATCMD: next_rdData = statusNow;
                default: next_rdData = 8'h00;
            endcase
        end
    end

    // Read data is registered and stands until the next read
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdData <= 8'h00;
        end else if (hostReq.rd) begin
            rdData <= next_rdData;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_CMD_CLEARS_UPPER: assert property (
        wrAccept && hits(hostReq, `DTF_SEL_STATCMD) && !hostReq.rd && !done.valid
        |=> !upperSel && !errFlag)
        else $error("Command write left upper select or error flag set");

    AST_SOFT_RESET_BIT_DEFAULTS: assert property (
        softReset |=> countCur == `DTF_RST_COUNT && !pending && !intrq)
        else $error("Soft reset did not hold task file at defaults");

    AST_IRQ_GATED: assert property (
        intrq |-> $past(pending) && !$past(ienN) && $past(devSelected))
        else $error("Interrupt raised while disabled or deselected");

    AST_WRITE_GATE: assert property (
        hostReq.rd && hostReq.sel == `DTF_SEL_DRVADDR && !drive.busy
        |=> rdData[6] == !$past(drive.writing) && rdData[5:2] == ~$past(drive.head))
        else $error("Drive address byte wrong");

    AST_COUNT_RESULT: assert property (
        done.valid && !softReset |=> countCur == ($past(done.ok) ? 8'h00 : $past(done.remain)))
        else $error("Count not updated at completion");

    AST_STATUS_ACK: assert property (
        statusRead && !done.valid && !softReset |=> !pending ##1 !intrq)
        else $error("Status read did not acknowledge");

    AST_ALT_KEEPS: assert property (
        pending && hostReq.rd && hostReq.sel == `DTF_SEL_ALT && !softReset |=> pending)
        else $error("Alternate status read cleared interrupt");

    AST_READY_HOLD: assert property (
        ((done.valid && !done.ok) || (readyHold && !statusRead)) && !softReset
        |=> !statusNow[`DTF_ST_READY])
        else $error("Ready returned before status read");

    AST_BUSY_STATUS: assert property (
        hostReq.rd && drive.busy |=> rdData[`DTF_ST_BUSY] && !rdData[`DTF_ST_FAULT]
        && !rdData[`DTF_ST_CORRECTED_FLAG])
        else $error("Busy read did not return status");

    AST_ERR_MASKED: assert property (
        done.valid && !done.isDiag && !softReset |=> (errReg & ~`DTF_ERR_MASK) == 8'h00)
        else $error("Reserved error bits set");

endmodule : dtf_task_file

`default_nettype wire

// ### dtf_map.svh
`ifndef DTF_MAP_SVH
`define DTF_MAP_SVH

// ----------------------------------------
// Register select codes on the task-file port
// ----------------------------------------
`define DTF_SEL_ALT 3'h0
`define DTF_SEL_ERRFEAT 3'h1
`define DTF_SEL_COUNT 3'h2
`define DTF_SEL_SECTOR 3'h3
`define DTF_SEL_DRVADDR 3'h4
`define DTF_SEL_DEVHEAD 3'h6
`define DTF_SEL_STATCMD 3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DTF_DC_UPPER 7
`define DTF_DC_SOFT_RESET_BIT 2
`define DTF_DC_IEN 1
`define DTF_DH_LBA 6
`define DTF_DH_DEV 4
`define DTF_ST_BUSY 7
`define DTF_ST_READY 6
`define DTF_ST_FAULT 5
`define DTF_ST_SEEK 4
`define DTF_ST_CORRECTED_FLAG 2
`define DTF_ST_ERR 0

// ----------------------------------------
// Reset values, masks, identity and timing
// ----------------------------------------
`define DTF_RST_COUNT 8'h01
`define DTF_RST_SECTOR 8'h01
`define DTF_RST_DEVHEAD 8'h00
`define DTF_RST_DEVCTL 8'h00
`define DTF_DIAG_PASS 8'h01
`define DTF_ERR_MASK 8'hd6
`define DTF_DEV_ID 1'b0
`define DTF_SOFT_RESET_BIT_MIN_NS 5000
`define DTF_CLK_NS 5
`define DTF_SOFT_RESET_BIT_MIN_CYC ((`DTF_SOFT_RESET_BIT_MIN_NS + `DTF_CLK_NS - 1) / `DTF_CLK_NS)

`endif

// ### dtf_pkg.sv
package dtf_pkg;

    // Host access to the task file, one access per strobe
    typedef struct packed {
        logic [2:0] sel;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } dtf_host_s;

    // Live state of the drive engine
    typedef struct packed {
        logic busy;
        logic data_request_flag;
        logic seekDone;
        logic writing;
        logic index;
        logic powerReady;
        logic [3:0] head;
    } dtf_drive_s;

    // Command end report from the drive engine
    typedef struct packed {
        logic valid;
        logic ok;
        logic isDiag;
        logic [7:0] errBits;
        logic [7:0] remain;
        logic [7:0] sectorNow;
        logic [3:0] headNow;
    } dtf_done_s;

endpackage : dtf_pkg

// ### dtf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "dtf_map.svh"

// ----------------------------------------
// Host adapter model on the task-file port
// ----------------------------------------
module dtf_host_model
    import dtf_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Data request flag as the host sees it
    input wire logic drqSeen,
    // Task-file access
    output var dtf_host_s hostReq
);
    int waitCnt; // Bound on the data request wait

    initial hostReq = '0;

    // One write strobe, taken at exactly one edge
    task automatic hWr(input logic [2:0] sel, input logic [7:0] d);
        waitCnt = 0;
        // A command waits while a data transfer is pending
        while (sel == `DTF_SEL_STATCMD && drqSeen && waitCnt < 100) begin
            @(posedge mclk);
            waitCnt++;
        end
        // A data request that never drops counts as a mismatch
        if (waitCnt >= 100) testbench.err_count++;
        @(posedge mclk);
        #1 hostReq = '{sel: sel, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge mclk);
        // Released data is inverted so no stale byte looks valid
        #1 hostReq = '{sel: sel, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask : hWr

    // One read strobe
    task automatic hRd(input logic [2:0] sel);
        @(posedge mclk);
        #1 hostReq = '{sel: sel, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge mclk);
        #1 hostReq = '{sel: sel, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
    endtask : hRd

    // Keep soft reset set long enough to be recognised
    task automatic srstHold();
        repeat (`DTF_SOFT_RESET_BIT_MIN_CYC) @(posedge mclk);
    endtask : srstHold
endmodule : dtf_host_model
`default_nettype wire

// ### dtf_testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "dtf_map.svh"

module testbench;
    import dtf_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic mclk, rst_b, intrq, cmdStrobe, devReset, lbaMode, rdA, rdB;
    dtf_host_s hostReq; // From the host model
    dtf_drive_s drive; // Engine state, driven here
    dtf_done_s done; // Engine completion reports
    logic [7:0] rdData, cmdCode, featureCode, a, b, code;
    logic [8:0] count28;
    logic [16:0] count48;
    logic [31:0] lfsr; // Random source
    logic [7:0] expQ[$]; // Expected read data, oldest first
    int err_count, check_count;

    dtf_host_model u_host (.mclk(mclk), .drqSeen(drive.data_request_flag), .hostReq(hostReq));
    dtf_task_file u_dut (.mclk(mclk), .rst_b(rst_b), .hostReq(hostReq), .rdData(rdData),
        .intrq(intrq), .drive(drive), .done(done), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
        .featureCode(featureCode), .devReset(devReset), .lbaMode(lbaMode), .count28(count28),
        .count48(count48));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] nextRand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : nextRand

    task automatic chkRd(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chkRd

    task automatic chkOut(input string what, input logic [16:0] exp, input logic [16:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chkOut

    // Note the expectation, then read
    task automatic rdx(input logic [2:0] sel, input logic [7:0] exp);
        expQ.push_back(exp);
        u_host.hRd(sel);
    endtask : rdx

    // Completion pulse; returns once intrq has had time to rise
    task automatic endCmd(input logic ok, input logic dg, input logic [7:0] eb, input logic [7:0] rem,
        input logic [7:0] sec, input logic [3:0] hd);
        @(posedge mclk);
        #1 done = '{valid: 1'b1, ok: ok, isDiag: dg, errBits: eb, remain: rem, sectorNow: sec,
            headNow: hd};
        @(posedge mclk);
        #1 done.valid = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : endCmd

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // Read data lands at the strobe edge; it is checked after the following edge
    always @(posedge mclk) begin
        rdA <= hostReq.rd;
        rdB <= rdA;
    end
    always @(negedge mclk) if (rdB === 1'b1 && expQ.size() > 0) chkRd("rdData", expQ.pop_front(), rdData);

    // Hang guard
    initial begin
        #400000;
        err_count++;
        report_and_stop();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        err_count = 0;
        check_count = 0;
        lfsr = 32'h0001466a;
        drive = '{busy: 1'b0, data_request_flag: 1'b0, seekDone: 1'b1, writing: 1'b0, index: 1'b0,
            powerReady: 1'b1, head: 4'h0};
        done = '0;
        repeat (10) @(posedge mclk);
        #1 rst_b = 1'b1;
        // Reset defaults
        rdx(`DTF_SEL_STATCMD, 8'h50);
        rdx(`DTF_SEL_COUNT, 8'h01);
        rdx(`DTF_SEL_SECTOR, 8'h01);
        rdx(`DTF_SEL_DEVHEAD, 8'h00);
        rdx(`DTF_SEL_ERRFEAT, 8'h01);
        drive.data_request_flag = 1'b1;
        drive.index = 1'b1;
        rdx(`DTF_SEL_ALT, 8'h5a);
        drive.data_request_flag = 1'b0;
        drive.index = 1'b0;
        // Drive address with random head and write gate
        repeat (4) begin
            a = 8'(nextRand());
            drive.head = a[3:0];
            drive.writing = a[4];
            rdx(`DTF_SEL_DRVADDR, {1'b0, ~a[4], ~a[3:0], 2'b10});
        end
        drive.writing = 1'b0;
        // Upper byte select, count decoding, address mode
        for (int i = 0; i < 2; i++) begin
            a = (i == 0) ? 8'(nextRand()) : 8'h00;
            b = (i == 0) ? 8'(nextRand()) : 8'h00;
            u_host.hWr(`DTF_SEL_DEVHEAD, (i == 0) ? 8'h40 : 8'h00);
            u_host.hWr(`DTF_SEL_COUNT, a);
            u_host.hWr(`DTF_SEL_COUNT, b);
            u_host.hWr(`DTF_SEL_ALT, 8'h88);
            u_host.hWr(`DTF_SEL_ERRFEAT, a ^ b);
            rdx(`DTF_SEL_COUNT, a);
            u_host.hWr(`DTF_SEL_STATCMD, 8'h25);
            // Strobe stands for the one cycle after the command edge
            chkOut("cmdStrobe", 17'h1, cmdStrobe);
            chkOut("featureCode", {9'h0, a ^ b}, featureCode);
            chkOut("cmdCode", 17'h25, cmdCode);
            chkOut("lbaMode", 17'(i == 0), lbaMode);
            chkOut("count28", (b == 0) ? 17'h100 : {9'h0, b}, count28);
            chkOut("count48", ({a, b} == 0) ? 17'h10000 : {1'b0, a, b}, count48);
            rdx(`DTF_SEL_COUNT, b);
        end
        // Failed command with random error bits
        a = 8'(nextRand());
        endCmd(1'b0, 1'b0, a, 8'h03, 8'h77, 4'h2);
        chkOut("intrq", 17'h1, intrq);
        drive.seekDone = 1'b0;
        rdx(`DTF_SEL_ALT, 8'h11);
        repeat (2) @(posedge mclk);
        #1 chkOut("intrq", 17'h1, intrq);
        rdx(`DTF_SEL_ERRFEAT, a & `DTF_ERR_MASK);
        rdx(`DTF_SEL_COUNT, 8'h03);
        rdx(`DTF_SEL_STATCMD, 8'h11);
        repeat (2) @(posedge mclk);
        #1 chkOut("intrq", 17'h0, intrq);
        rdx(`DTF_SEL_ALT, 8'h41);
        drive.seekDone = 1'b1;
        // Next command clears error; LBA completion
        u_host.hWr(`DTF_SEL_DEVHEAD, 8'h40);
        u_host.hWr(`DTF_SEL_STATCMD, 8'hc8);
        rdx(`DTF_SEL_ALT, 8'h50);
        endCmd(1'b1, 1'b0, 8'h00, 8'h00, 8'h9c, 4'ha);
        chkOut("intrq", 17'h1, intrq);
        rdx(`DTF_SEL_COUNT, 8'h00);
        rdx(`DTF_SEL_SECTOR, 8'h9c);
        rdx(`DTF_SEL_DEVHEAD, 8'h4a);
        rdx(`DTF_SEL_ERRFEAT, 8'h00);
        rdx(`DTF_SEL_STATCMD, 8'h50);
        // Interrupt disabled, then device not selected
        for (int i = 0; i < 2; i++) begin
            u_host.hWr(`DTF_SEL_ALT, (i == 0) ? 8'h0a : 8'h08);
            u_host.hWr(`DTF_SEL_DEVHEAD, (i == 0) ? 8'h00 : 8'h10);
            endCmd(1'b1, 1'b0, 8'h00, 8'h00, 8'h01, 4'h0);
            chkOut("intrq", 17'h0, intrq);
            rdx(`DTF_SEL_STATCMD, 8'h50);
        end
        u_host.hWr(`DTF_SEL_DEVHEAD, 8'h00);
        // Busy: reads return status, writes dropped
        drive.busy = 1'b1;
        u_host.hWr(`DTF_SEL_COUNT, 8'h5a);
        rdx(`DTF_SEL_ERRFEAT, 8'hd0);
        drive.busy = 1'b0;
        rdx(`DTF_SEL_COUNT, 8'h00);
        // Diagnostic completion
        code = 8'h01 + 8'(nextRand() % 5);
        endCmd(1'b1, 1'b1, code, 8'h00, 8'h01, 4'h0);
        rdx(`DTF_SEL_ERRFEAT, code);
        rdx(`DTF_SEL_STATCMD, 8'h50);
        // Soft reset
        u_host.hWr(`DTF_SEL_COUNT, 8'h33);
        u_host.hWr(`DTF_SEL_ALT, 8'h0c);
        @(posedge mclk);
        #1 chkOut("devReset", 17'h1, devReset);
        u_host.hWr(`DTF_SEL_COUNT, 8'h44);
        u_host.srstHold();
        u_host.hWr(`DTF_SEL_ALT, 8'h08);
        @(posedge mclk);
        #1 chkOut("devReset", 17'h0, devReset);
        rdx(`DTF_SEL_COUNT, 8'h01);
        rdx(`DTF_SEL_ERRFEAT, 8'h01);
        rdx(`DTF_SEL_STATCMD, 8'h50);
        repeat (4) @(posedge mclk);
        chkOut("pending reads", 17'h0, 17'(expQ.size()));
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
